// file: pkg/mta_regs.vh
// constants for the memory-mapped target responder
// assumes a 32-bit packet stream from the endpoint core, one beat per dword
//
// Contract
// - four 2 KB regions, 8192 bytes total
// - each region its own dual-port RAM
// - accept single-dword IO and memory requests
// - reads answered with one-dword data completion
// - IO write answered by successful dataless completion
// - writes store payload; memory writes not completed
// - target only, never originates requests
// - core drives match vector; responder decodes it
// - IO region served only when enabled
// - one IO, mem32, mem64 and ROM window each
// - extra windows of a type get nothing
// - wider windows wrap onto 2 KB
// - multi-dword requests consumed, then dropped silently
// - receive readiness withdrawn during access
`ifndef MTA_REGS_VH
`define MTA_REGS_VH

// header field positions, dword 0
`define MTA_FMT_HI 30
`define MTA_FMT_LO 29
`define MTA_TYPE_HI 28
`define MTA_TYPE_LO 24
`define MTA_LEN_HI 9
`define MTA_LEN_LO 0

// fmt and type codes
`define MTA_FMT_3DW_NODATA 2'h0
`define MTA_FMT_4DW_NODATA 2'h1
`define MTA_FMT_3DW_DATA 2'h2
`define MTA_FMT_4DW_DATA 2'h3
`define MTA_TYPE_MEM 5'h00
`define MTA_TYPE_IO 5'h02
`define MTA_TYPE_CPL 5'h0A

// match-vector patterns, active low
`define MTA_HIT_MEM32 7'h7B
`define MTA_HIT_MEM64 7'h7C
`define MTA_HIT_ROM 7'h3F

// region indices
`define MTA_RGN_IO 2'h0
`define MTA_RGN_MEM32 2'h1
`define MTA_RGN_MEM64 2'h2
`define MTA_RGN_ROM 2'h3

// completion constants
`define MTA_CPL_BYTES 12'h004
`define MTA_CPL_STATUS_OK 3'h0
`define MTA_LEN_ONE 10'h001

`endif

// file: verilog/mta_skid.v
// two-entry skid buffer with registered outputs
// assumes the drain side may stall at any time; no word is lost
`timescale 1ns/100ps
`default_nettype none

module mta_skid #(
  parameter WIDTH = 34
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // drain side
  output reg out_valid,
  output reg [WIDTH-1:0] out_data,
  input wire out_ready
);

  reg skid_valid_r;
  reg [WIDTH-1:0] skid_data_r;

  // ready only depends on a flop, so no combinational path back to the source
  assign in_ready = ~skid_valid_r;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
      skid_valid_r <= 1'b0;
      skid_data_r <= {WIDTH{1'b0}};
    end else begin
      if (!out_valid || out_ready) begin
        if (skid_valid_r) begin
          out_valid <= 1'b1;
          out_data <= skid_data_r;
          skid_valid_r <= 1'b0;
        end else begin
          out_valid <= in_valid;
          if (in_valid) begin
            out_data <= in_data;
          end
        end
      end else if (in_valid && !skid_valid_r) begin
        skid_valid_r <= 1'b1;
        skid_data_r <= in_data;
      end
    end
  end

endmodule // mta_skid

`default_nettype wire

// file: verilog/mta_target.v
// memory-mapped target responder: packet receive, four region RAMs, completions
// assumes a 32-bit receive/transmit packet stream from the endpoint core,
// one dword per beat, match vector valid on the start beat
`timescale 1ns/100ps
`default_nettype none
`include "mta_regs.vh"

module mta_target #(
  parameter IO_EN = 1'b0,
  parameter [2:0] IO_BAR = 3'h0,
  parameter AW = 9
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RESETN,
  // configuration from the core
  input wire [15:0] CPL_ID,
  // receive stream
  input wire [31:0] RX_DATA,
  input wire RX_SOF,
  input wire RX_EOF,
  input wire RX_VALID,
  input wire [6:0] RX_BAR_HIT_N,
  output reg RX_READY,
  // transmit stream
  output wire [31:0] TX_DATA,
  output wire TX_SOF,
  output wire TX_EOF,
  output wire TX_VALID,
  input wire TX_READY
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RECV = 3'h1;
  localparam [2:0] ST_WR = 3'h2;
  localparam [2:0] ST_RD = 3'h3;
  localparam [2:0] ST_RDW = 3'h4;
  localparam [2:0] ST_CPL = 3'h5;

  reg [2:0] state_r, state_nxt;
  reg [2:0] wcnt_r;
  reg [1:0] fmt_r;
  reg [4:0] type_r;
  reg [2:0] tc_r;
  reg [1:0] attr_r;
  reg [9:0] len_r;
  reg [15:0] req_id_r;
  reg [7:0] tag_r;
  reg [3:0] be_r;
  reg [AW-1:0] addr_r;
  reg [6:0] low_addr_r;
  reg [31:0] wdata_r;
  reg [1:0] rgn_r;
  reg rgn_ok_r;
  reg [31:0] rdata_r;
  reg [1:0] cidx_r;
  reg cpl_data_r;

  wire rx_take = RX_VALID && RX_READY;
  wire sk_in_ready;
  wire hdr4 = fmt_r[0];
  wire has_data = fmt_r[1];
  wire is_io = (type_r == `MTA_TYPE_IO);
  wire is_mem = (type_r == `MTA_TYPE_MEM);
  wire addr_beat = hdr4 ? (wcnt_r == 3'h3) : (wcnt_r == 3'h2);
  wire data_beat = hdr4 ? (wcnt_r == 3'h4) : (wcnt_r == 3'h3);
  wire [2:0] last_idx = hdr4 ? 3'h4 : 3'h3;

  // region decode from the active-low match vector; anything else is unserved
  reg [1:0] hit_rgn;
  reg hit_ok;
  always @* begin
    hit_rgn = `MTA_RGN_IO;
    hit_ok = 1'b0;
    if (RX_BAR_HIT_N == `MTA_HIT_MEM32) begin
      hit_rgn = `MTA_RGN_MEM32;
      hit_ok = 1'b1;
    end else if (RX_BAR_HIT_N == `MTA_HIT_MEM64) begin
      hit_rgn = `MTA_RGN_MEM64;
      hit_ok = 1'b1;
    end else if (RX_BAR_HIT_N == `MTA_HIT_ROM) begin
      hit_rgn = `MTA_RGN_ROM;
      hit_ok = 1'b1;
    end else if (IO_EN && (RX_BAR_HIT_N == ~(7'h01 << IO_BAR))) begin
      hit_rgn = `MTA_RGN_IO;
      hit_ok = 1'b1;
    end
    // other windows, including extra ones of a served type, fall through
  end

  // request is acted on only if single dword, known type, served region
  wire len_one = (len_r == `MTA_LEN_ONE);
  // each region serves its own category only: io type on io window, memory elsewhere
  wire type_ok = is_io ? (rgn_r == `MTA_RGN_IO) : (is_mem && (rgn_r != `MTA_RGN_IO));
  wire valid_req = rgn_ok_r && len_one && type_ok;

  // state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rx_take && RX_SOF) begin
          state_nxt = RX_EOF ? ST_IDLE : ST_RECV;
        end
      end
      ST_RECV: begin
        if (rx_take && RX_EOF) begin
          // stray beats past the header are still drained before deciding
          if (!valid_req || (has_data && !data_beat) || (!has_data && !addr_beat)) begin
            state_nxt = ST_IDLE;
          end else if (has_data) begin
            state_nxt = ST_WR;
          end else begin
            state_nxt = ST_RD;
          end
        end
      end
      ST_WR: state_nxt = is_io ? ST_CPL : ST_IDLE;
      ST_RD: state_nxt = ST_RDW;
      ST_RDW: state_nxt = ST_CPL;
      ST_CPL: begin
        if (sk_in_ready && ((cpl_data_r && cidx_r == 2'h3) || (!cpl_data_r && cidx_r == 2'h2))) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      RX_READY <= 1'b0;
      wcnt_r <= 3'h0;
      fmt_r <= 2'h0;
      type_r <= 5'h00;
      tc_r <= 3'h0;
      attr_r <= 2'h0;
      len_r <= 10'h000;
      req_id_r <= 16'h0000;
      tag_r <= 8'h00;
      be_r <= 4'h0;
      addr_r <= {AW{1'b0}};
      low_addr_r <= 7'h00;
      wdata_r <= 32'h00000000;
      rgn_r <= 2'h0;
      rgn_ok_r <= 1'b0;
      cidx_r <= 2'h0;
      cpl_data_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // ready held low from the end beat until the access is done
      RX_READY <= (state_nxt == ST_IDLE) || (state_nxt == ST_RECV);
      if (rx_take) begin
        if (RX_SOF) begin
          wcnt_r <= 3'h1;
          fmt_r <= RX_DATA[`MTA_FMT_HI:`MTA_FMT_LO];
          type_r <= RX_DATA[`MTA_TYPE_HI:`MTA_TYPE_LO];
          tc_r <= RX_DATA[22:20];
          attr_r <= RX_DATA[13:12];
          len_r <= RX_DATA[`MTA_LEN_HI:`MTA_LEN_LO];
          rgn_r <= hit_rgn;
          rgn_ok_r <= hit_ok;
        end else begin
          if (wcnt_r != 3'h7) begin
            wcnt_r <= wcnt_r + 3'h1;
          end
          if (wcnt_r == 3'h1) begin
            req_id_r <= RX_DATA[31:16];
            tag_r <= RX_DATA[15:8];
            be_r <= RX_DATA[3:0];
          end
          if (addr_beat) begin
            // only the low bits index the region, so wide windows wrap
            addr_r <= RX_DATA[AW+1:2];
            low_addr_r <= {RX_DATA[6:2], 2'h0};
          end
          if (data_beat && (wcnt_r == last_idx)) begin
            wdata_r <= RX_DATA;
          end
        end
      end
      if (state_nxt == ST_CPL && state_r != ST_CPL) begin
        cidx_r <= 2'h0;
        cpl_data_r <= !has_data;
      end else if (state_r == ST_CPL && sk_in_ready) begin
        cidx_r <= cidx_r + 2'h1;
      end
    end
  end

  // region RAMs, one dual-port array each: write port and read port apart
  wire [31:0] rd_q [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rgn
      reg [31:0] ram [0:(1<<AW)-1];
      reg [31:0] q_r;
      wire sel = ({30'h0, rgn_r} == g);
      always @(posedge CLK_SYS) begin
        if (state_r == ST_WR && sel) begin
          if (be_r[0]) ram[addr_r][7:0] <= wdata_r[7:0];
          if (be_r[1]) ram[addr_r][15:8] <= wdata_r[15:8];
          if (be_r[2]) ram[addr_r][23:16] <= wdata_r[23:16];
          if (be_r[3]) ram[addr_r][31:24] <= wdata_r[31:24];
        end
        if (state_r == ST_RD && sel) begin
          q_r <= ram[addr_r];
        end
      end
      assign rd_q[g] = q_r;
    end
  endgenerate

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= 32'h00000000;
    end else if (state_r == ST_RDW) begin
      rdata_r <= rd_q[rgn_r];
    end
  end

  // completion words; only completions are ever sent
  reg [31:0] cpl_word;
  always @* begin
    case (cidx_r)
      2'h0: cpl_word = {1'b0, (cpl_data_r ? `MTA_FMT_3DW_DATA : `MTA_FMT_3DW_NODATA),
                        `MTA_TYPE_CPL, 1'b0, tc_r, 4'h0, 2'h0, attr_r, 2'h0,
                        (cpl_data_r ? `MTA_LEN_ONE : 10'h000)};
      2'h1: cpl_word = {CPL_ID, `MTA_CPL_STATUS_OK, 1'b0, `MTA_CPL_BYTES};
      2'h2: cpl_word = {req_id_r, tag_r, 1'b0, low_addr_r};
      default: cpl_word = rdata_r;
    endcase
  end

  wire cpl_last = cpl_data_r ? (cidx_r == 2'h3) : (cidx_r == 2'h2);

  // stalls on the transmit side hold the completion state machine
  mta_skid #(
    .WIDTH(34)
  ) u_skid (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .in_valid(state_r == ST_CPL),
    .in_data({cidx_r == 2'h0, cpl_last, cpl_word}),
    .in_ready(sk_in_ready),
    .out_valid(TX_VALID),
    .out_data({TX_SOF, TX_EOF, TX_DATA}),
    .out_ready(TX_READY)
  );

endmodule // mta_target

`default_nettype wire

// file: sim/mta_core_model.sv
// core model, transmit side: takes completion beats
// assumes slow makes ready high every other cycle
`timescale 1ns/100ps
`default_nettype none
module mta_core_model (
  // clock and reset
  input wire CLK_SYS,
  input wire RESETN,
  // completion stream
  input wire [31:0] TX_DATA,
  input wire TX_SOF,
  input wire TX_EOF,
  input wire TX_VALID,
  output logic TX_READY,
  // pacing
  input wire slow
);
  logic [33:0] w [0:63];
  int cnt;
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      TX_READY <= 1'b0;
      cnt <= 0;
    end else begin
      TX_READY <= slow ? !TX_READY : 1'b1;
      if (TX_VALID && TX_READY) begin
        w[cnt[5:0]] <= {TX_SOF, TX_EOF, TX_DATA};
        cnt <= cnt + 1;
      end
    end
  end
endmodule // mta_core_model
`default_nettype wire

// file: sim/mta_target_chk.sv
// checker for mta_target stream handshakes and completions
// assumes binding to the top module ports
`timescale 1ns/100ps
`default_nettype none
module mta_target_chk (
  // clock and reset
  input wire CLK_SYS,
  input wire RESETN,
  // receive
  input wire [15:0] CPL_ID,
  input wire [31:0] RX_DATA,
  input wire RX_SOF,
  input wire RX_EOF,
  input wire RX_VALID,
  input wire [6:0] RX_BAR_HIT_N,
  input wire RX_READY,
  // transmit
  input wire [31:0] TX_DATA,
  input wire TX_SOF,
  input wire TX_EOF,
  input wire TX_VALID,
  input wire TX_READY
);
  reg [31:0] hdr_r;
  reg [6:0] hit_r;
  reg [2:0] n_r;
  reg [1:0] t_r;
  reg cpld_r;
  wire rx_go = RX_VALID && RX_READY;
  wire tx_go = TX_VALID && TX_READY;
  wire eof = rx_go && RX_EOF && !RX_SOF;
  wire m32 = eof && hdr_r[28:24] == 5'h00 && hdr_r[9:0] == 10'h001 && hit_r == 7'h7B;
  wire wr_ok = m32 && hdr_r[30:29] == 2'h2 && n_r == 3'h3;
  wire rd_ok = m32 && hdr_r[30:29] == 2'h0 && n_r == 3'h2;
  wire drop = eof && hdr_r[9:0] != 10'h001;
  always @(posedge CLK_SYS) begin
    if (rx_go && RX_SOF) begin
      hdr_r <= RX_DATA;
      hit_r <= RX_BAR_HIT_N;
    end
  end
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      n_r <= 3'h0;
      t_r <= 2'h0;
      cpld_r <= 1'b0;
    end else begin
      if (rx_go)
        n_r <= RX_SOF ? 3'h1 : n_r + 3'h1;
      if (tx_go)
        t_r <= TX_EOF ? 2'h0 : t_r + 2'h1;
      if (tx_go && TX_SOF)
        cpld_r <= TX_DATA[30];
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  AST_WR_STALL: assert property (wr_ok |=> !RX_READY ##1 RX_READY)
    else $error("write stall not one cycle");
  AST_RD_CPL: assert property (rd_ok |-> ##[4:60] (tx_go && TX_EOF))
    else $error("read got no completion");
  AST_MWR_NOCPL: assert property (wr_ok && !TX_VALID |=> !TX_VALID [*6])
    else $error("memory write completed");
  AST_DROP: assert property (drop |=> RX_READY [*3])
    else $error("dropped packet stalled receive");
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("transmit beat changed");
  AST_TX_LEN: assert property (tx_go && TX_EOF |-> t_r == (cpld_r ? 2'h3 : 2'h2))
    else $error("completion length wrong");
  AST_CPL_ONLY: assert property (tx_go && TX_SOF |-> TX_DATA[28:24] == 5'h0A && t_r == 2'h0)
    else $error("non completion sent");
  AST_CPL_ID: assert property (tx_go && t_r == 2'h1 |-> TX_DATA == {CPL_ID, 16'h0004})
    else $error("completer word wrong");
  COV_WR: cover property (wr_ok);
  COV_RD: cover property (rd_ok);
  COV_STALL: cover property (TX_VALID && !TX_READY);
endmodule // mta_target_chk
bind mta_target mta_target_chk u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .CPL_ID(CPL_ID),
  .RX_DATA(RX_DATA), .RX_SOF(RX_SOF), .RX_EOF(RX_EOF), .RX_VALID(RX_VALID),
  .RX_BAR_HIT_N(RX_BAR_HIT_N), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_SOF(TX_SOF),
  .TX_EOF(TX_EOF), .TX_VALID(TX_VALID), .TX_READY(TX_READY));
`default_nettype wire

// file: sim/test_mta_target.sv
// testbench for mta_target: directed requests, core model on transmit
// assumes the checker is bound to the top module
`timescale 1ns/100ps
`default_nettype none
module test_mta_target;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid = 1'b0, rx_sof = 1'b0, rx_eof = 1'b0, slow = 1'b0;
  logic [31:0] rx_data = 32'h0;
  logic [6:0] rx_hit_n = 7'h7F;
  logic [15:0] cpl_id = 16'h1234;
  wire rx_ready, tx_sof, tx_eof, tx_valid, tx_ready;
  wire [31:0] tx_data;
  int err_total = 0;
  int n_tests = 0;
  int seen = 0;
  always #10 clk = ~clk;
  mta_target #(.IO_EN(1'b1), .IO_BAR(3'h0), .AW(9)) uut (.CLK_SYS(clk), .RESETN(rst_n),
    .CPL_ID(cpl_id), .RX_DATA(rx_data), .RX_SOF(rx_sof), .RX_EOF(rx_eof),
    .RX_VALID(rx_valid), .RX_BAR_HIT_N(rx_hit_n), .RX_READY(rx_ready), .TX_DATA(tx_data),
    .TX_SOF(tx_sof), .TX_EOF(tx_eof), .TX_VALID(tx_valid), .TX_READY(tx_ready));
  mta_core_model u_core (.CLK_SYS(clk), .RESETN(rst_n), .TX_DATA(tx_data), .TX_SOF(tx_sof),
    .TX_EOF(tx_eof), .TX_VALID(tx_valid), .TX_READY(tx_ready), .slow(slow));
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("mismatches %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // one request; caller sits just after a clock edge
  task automatic req(input [1:0] fmt, input [4:0] typ, input [9:0] len, input [6:0] hit,
      input [31:0] addr, input [31:0] data);
    logic [31:0] b [0:7];
    int n, k, t;
    b[0] = {1'b0, fmt, typ, 1'b0, 3'h5, 10'h004, len};
    b[1] = {16'hA5C3, 8'h3C, 8'h0F};
    b[2] = 32'h0000_0001;
    n = fmt[0] ? 3 : 2;
    b[n] = addr;
    n++;
    for (k = 0; fmt[1] && k < len; k++) begin
      b[n] = data + k;
      n++;
    end
    for (k = 0; k < n; k++) begin
      rx_valid = 1'b1;
      rx_sof = (k == 0);
      rx_eof = (k == n - 1);
      rx_data = b[k];
      rx_hit_n = hit;
      for (t = 0; t < 200 && rx_ready !== 1'b1; t++)
        step();
      if (t == 200) begin
        err_total++;
        results();
      end
      step();
    end
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    // released lines show the inverse, not the last value
    rx_data = ~b[n-1];
    rx_hit_n = ~hit;
    // one idle edge so the next request never re-raises valid in this time step
    step();
  endtask
  task automatic cpl(input logic isd, input [31:0] addr, input [31:0] data);
    logic [33:0] e [0:3];
    int t, nw;
    nw = isd ? 4 : 3;
    for (t = 0; t < 300 && u_core.cnt < seen + nw; t++)
      step();
    if (t == 300) begin
      err_total++;
      results();
    end
    e[0] = {2'b10, 1'b0, isd ? 2'h2 : 2'h0, 5'h0A, 1'b0, 3'h5, 10'h004, 9'h0, isd};
    e[1] = {2'b00, cpl_id, 16'h0004};
    e[2] = {1'b0, !isd, 16'hA5C3, 8'h3C, 1'b0, addr[6:2], 2'h0};
    e[3] = {2'b01, data};
    for (t = 0; t < nw; t++)
      check(u_core.w[seen + t], e[t]);
    seen += nw;
  endtask
  task automatic none;
    repeat (20) step();
    check(34'(u_core.cnt), 34'(seen));
  endtask
  task automatic t_mem32;
    req(2'h2, 5'h00, 10'h001, 7'h7B, 32'h14, 32'hCAFE_0001);
    slow = 1'b1;
    req(2'h0, 5'h00, 10'h001, 7'h7B, 32'h14, 32'h0);
    cpl(1'b1, 32'h14, 32'hCAFE_0001);
    slow = 1'b0;
  endtask
  task automatic t_wrap;
    req(2'h3, 5'h00, 10'h001, 7'h7C, 32'h808, 32'hBEE5_0002);
    req(2'h1, 5'h00, 10'h001, 7'h7C, 32'h08, 32'h0);
    cpl(1'b1, 32'h08, 32'hBEE5_0002);
  endtask
  task automatic t_regions;
    req(2'h2, 5'h02, 10'h001, 7'h7E, 32'h14, 32'h1000_0003);
    cpl(1'b0, 32'h14, 32'h0);
    req(2'h2, 5'h00, 10'h001, 7'h3F, 32'h14, 32'h2000_0004);
    req(2'h0, 5'h02, 10'h001, 7'h7E, 32'h14, 32'h0);
    cpl(1'b1, 32'h14, 32'h1000_0003);
    req(2'h0, 5'h00, 10'h001, 7'h3F, 32'h14, 32'h0);
    cpl(1'b1, 32'h14, 32'h2000_0004);
  endtask
  task automatic t_drop;
    req(2'h2, 5'h00, 10'h002, 7'h7B, 32'h14, 32'hDEAD_0005);
    none();
    req(2'h0, 5'h00, 10'h001, 7'h77, 32'h14, 32'h0);
    req(2'h0, 5'h02, 10'h001, 7'h7B, 32'h14, 32'h0);
    none();
    req(2'h0, 5'h00, 10'h001, 7'h7B, 32'h14, 32'h0);
    cpl(1'b1, 32'h14, 32'hCAFE_0001);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step();
    t_mem32();
    t_wrap();
    t_regions();
    t_drop();
    results();
  end
endmodule // test_mta_target
`default_nettype wire
